//--- design/cod_regs.svh
// Purpose: option byte indices, bit positions, erased values and decode results
// Assumes: three option bytes, each eight bits wide
// Notes: definitions only
`ifndef COD_REGS_SVH
`define COD_REGS_SVH

`define COD_NBYTES      3
`define COD_IDX_BOOT    2'h0
`define COD_IDX_PART    2'h1
`define COD_IDX_BOD     2'h2
`define COD_ERASED      8'hFF
`define COD_BLANK       8'hFF

`define COD_BIT_BOOTSEL 7
`define COD_BIT_PWMTRI  5
`define COD_BIT_DBGEN_N 4
`define COD_BIT_RSTPIN  2
`define COD_BIT_LOCK    1

`define COD_LDSZ_MSB    2
`define COD_LDSZ_LSB    0

`define COD_BIT_BODON   7
`define COD_BODLV_MSB   5
`define COD_BODLV_LSB   4
`define COD_BIT_BODINH  3
`define COD_BIT_BODRST  2

// threshold in tenths of a volt
`define COD_BOD_22      6'h16
`define COD_BOD_27      6'h1B
`define COD_BOD_37      6'h25
`define COD_BOD_44      6'h2C

// loader and application sizes in kilobytes
`define COD_LDR_0K      3'h0
`define COD_LDR_1K      3'h1
`define COD_LDR_2K      3'h2
`define COD_LDR_3K      3'h3
`define COD_LDR_4K      3'h4
`define COD_APP_18K     5'h12
`define COD_APP_17K     5'h11
`define COD_APP_16K     5'h10
`define COD_APP_15K     5'h0F
`define COD_APP_14K     5'h0E

`endif

//--- design/cod_pkg.sv
// Purpose: types shared by the option decoder files
// Assumes: constants come from cod_regs.svh
// Notes: none
package cod_pkg;

   localparam int PWM_CH = 6;

   typedef enum logic {ST_LOAD, ST_RUN} cod_phase_t;

   // one request from the programmer or from in-application programming
   typedef struct packed {
      logic       valid;
      logic       write;
      logic       eraseAll;
      logic       optSel;
      logic [1:0] idx;
      logic [7:0] wdata;
   } cod_req_t;

   // register copies of option bits that software may change
   typedef struct packed {
      logic       bootApp;
      logic       pinIsReset;
      logic       bodOn;
      logic [1:0] bodLevel;
      logic       bodInhibit;
      logic       bodReset;
   } cod_sfr_t;

   typedef struct packed {
      cod_phase_t        phase;
      cod_sfr_t          sfr;
      logic [2:0]        loaderK;
      logic [4:0]        appK;
      logic [5:0]        bodDeciV;
      logic              dbgActive;
      logic [PWM_CH-1:0] pwmTri;
      logic              hardFaultFlag;
      logic              hardFaultRst;
      logic              extRstReq;
      logic              gpioIn;
      logic              iapInhibit;
      logic              bodRstReq;
      logic              oscOn;
      logic [7:0]        toolRdata;
      logic              toolAck;
      logic              flashWr;
      logic              flashErase;
      logic              iapFlashWr;
      logic              iapAck;
      logic              iapBlocked;
      logic              dbgAck;
      logic              dbgRefused;
   } cod_state_t;

endpackage : cod_pkg

//--- design/cod_sync2.sv
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: INIT is the idle level of each pin
// Notes: nothing but the second flop is read outside
`timescale 1ns/1ps
module cod_sync2 #(
   parameter int           W    = 1,
   parameter logic [W-1:0] INIT = '0
)(
   input  wire logic         clock,  // system clock
   input  wire logic         rstn,   // synchronised reset, low
   input  wire logic [W-1:0] din,    // asynchronous level
   output logic      [W-1:0] dout    // synchronised level
);
   logic [W-1:0] stage1Q;

   initial
   begin
      if (W < 1) $error("cod_sync2: W must be at least 1");
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         stage1Q <= INIT;
         dout    <= INIT;
      end
      else
      begin
         stage1Q <= din;
         dout    <= stage1Q;
      end
   end
endmodule : cod_sync2

//--- design/cod_option_store.sv
// Purpose: non-volatile option byte store with one write port and whole erase
// Assumes: contents survive rst_b, as the cells are non-volatile
// Notes: erase wins over a write in the same cycle
`timescale 1ns/1ps
`include "cod_regs.svh"
module cod_option_store #(
   parameter int NBYTES = `COD_NBYTES
)(
   input  wire logic                   clock,    // system clock
   input  wire logic                   wrEn,     // write one byte
   input  wire logic [1:0]             wrIdx,    // byte index
   input  wire logic [7:0]             wrData,   // byte value
   input  wire logic                   eraseAll, // erase every byte
   output logic [NBYTES-1:0][7:0]      rdData    // stored bytes, registered
);
   logic [NBYTES-1:0][7:0] memD;

   initial
   begin
      if (NBYTES < 3 || NBYTES > 4) $error("cod_option_store: NBYTES must be 3 or 4");
   end

   always_comb
   begin
      memD = rdData;
      if (eraseAll)
         memD = {NBYTES{`COD_ERASED}};
      else if (wrEn && (32'(wrIdx) < NBYTES))
         memD[wrIdx] = wrData;
   end

   // no reset: the cells keep their value over every chip reset
   always_ff @(posedge clock)
   begin
      rdData <= memD;
   end
endmodule : cod_option_store

//--- design/cod_config_option_decoder.sv
// Purpose: decode option bytes, guard them with the lock, load register copies after reset
// Assumes: flash array, processor and debugger core sit outside on the same clock
// Notes: option bytes are not cleared by rst_b; erase them once after power-up
//
// What this block does
// - after non-software reset boot from application flash when bit 7 set
// - tri-state enabled PWM pins during debug halt when selected
// - debugger on when enable bit low; hard fault then only flags
// - shared pin is reset input or plain input by bit 2
// - locked chip returns FFH to tool flash reads and ignores their programming
// - option bytes always readable; locked ones cannot be written alone by tools
// - for tools only whole-chip erase unlocks, clearing flash and options together
// - in-application programming works the same when locked
// - loader size field decodes to loader and application flash sizes
// - brown-out detector on when bit 7 of brown-out byte set
// - brown-out level field selects 2.2, 2.7, 3.7 or 4.4 volts
// - brown-out inhibit blocks in-application erase and program below threshold
// - brown-out causes reset only when reset bit set
// - option bits copied to register bits after reset, boot bit not after software reset, brown-out bits on power-on only; software may change them
// - in debug keep fast oscillator running despite off request or power-down
// - debugger memory access only while halted at breakpoint or step
// - debugger stays inactive while chip is locked
`timescale 1ns/1ps
`include "cod_regs.svh"
module cod_config_option_decoder (
   input  wire logic                     clock,         // 200 MHz system clock
   input  wire logic                     rst_b,         // chip reset, low
   input  wire logic                     swResetCause,  // last reset was software reset
   input  wire logic                     porCause,      // last reset was power-on
   input  wire cod_pkg::cod_req_t        toolReq,       // external programmer request
   input  wire logic [7:0]               flashRdata,    // flash array read data
   input  wire cod_pkg::cod_req_t        iapReq,        // in-application request
   input  wire logic                     sfrWe,         // software writes register copies
   input  wire cod_pkg::cod_sfr_t        sfrWdata,      // new register copy values
   input  wire logic                     cpuHalted,     // halted at breakpoint or step
   input  wire logic                     dbgReq,        // debugger access request
   input  wire logic                     hardFaultEv,   // hard fault event
   input  wire logic                     hardFaultClr,  // software clears fault flag
   input  wire logic                     swOscOff,      // software turns fast osc off
   input  wire logic                     powerDown,     // processor in power-down
   input  wire logic [cod_pkg::PWM_CH-1:0] pwmPinOe,    // pwm pin output enables
   input  wire logic                     resetPinIn,    // shared reset pin level
   input  wire logic                     bodBelowIn,    // supply below threshold
   output logic                          bootFromApp,   // boot block select
   output logic [2:0]                    loaderSizeK,   // loader flash kilobytes
   output logic [4:0]                    appSizeK,      // application flash kilobytes
   output logic                          bodEnable,     // brown-out circuit on
   output logic [5:0]                    bodDeciVolt,   // threshold, tenths of volt
   output logic                          bodResetReq,   // brown-out reset request
   output logic                          iapInhibit,    // iap erase/program blocked
   output logic                          dbgActive,     // debugger enabled
   output logic [cod_pkg::PWM_CH-1:0]    pwmTristate,   // pwm pins to float
   output logic                          hardFaultFlag, // sticky fault flag
   output logic                          hardFaultRst,  // fault reset pulse
   output logic                          extResetReq,   // reset from shared pin
   output logic                          gpioIn,        // shared pin as port input
   output logic                          fastOscOn,     // fast oscillator enable
   output logic [7:0]                    toolRdata,     // data back to tool
   output logic                          toolAck,       // tool request done
   output logic                          flashWrite,    // tool flash program strobe
   output logic                          flashErase,    // whole flash erase strobe
   output logic                          iapFlashWrite, // iap flash program strobe
   output logic                          iapAck,        // iap request done
   output logic                          iapBlocked,    // iap request refused
   output logic                          dbgAck,        // debugger access taken
   output logic                          dbgRefused     // debugger access refused
);
   cod_pkg::cod_state_t    q;
   cod_pkg::cod_state_t    d;
   logic [1:0]             rstSyncQ;
   logic                   rstn;
   logic [2:0][7:0]        opt;
   logic                   resetPinS;
   logic                   bodBelowS;
   logic                   locked;
   logic                   storeWe;
   logic [1:0]             storeIdx;
   logic [7:0]             storeWd;
   logic                   storeErase;
   logic                   iapFlashOp;

   // release of reset is synchronised, assertion stays asynchronous
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         rstSyncQ <= 2'h0;
      else
         rstSyncQ <= {rstSyncQ[0], 1'b1};
   end
   assign rstn = rstSyncQ[1];

   cod_sync2 #(.W(2), .INIT(2'h1)) pinSync (
      .clock (clock),
      .rstn  (rstn),
      .din   ({bodBelowIn, resetPinIn}),
      .dout  ({bodBelowS, resetPinS})
   );

   cod_option_store #(.NBYTES(`COD_NBYTES)) optStore (
      .clock    (clock),
      .wrEn     (storeWe),
      .wrIdx    (storeIdx),
      .wrData   (storeWd),
      .eraseAll (storeErase),
      .rdData   (opt)
   );

   assign locked = ~opt[`COD_IDX_BOOT][`COD_BIT_LOCK];
   assign iapFlashOp = iapReq.valid & ~iapReq.optSel & (iapReq.write | iapReq.eraseAll);

   always_comb
   begin
      d = q;
      d.toolAck      = 1'b0;
      d.flashWr      = 1'b0;
      d.flashErase   = 1'b0;
      d.iapFlashWr   = 1'b0;
      d.iapAck       = 1'b0;
      d.iapBlocked   = 1'b0;
      d.dbgAck       = 1'b0;
      d.dbgRefused   = 1'b0;
      d.hardFaultRst = 1'b0;
      storeWe    = 1'b0;
      storeIdx   = 2'h0;
      storeWd    = 8'h00;
      storeErase = 1'b0;

      case (q.phase)
         cod_pkg::ST_LOAD:
         begin
            // software reset: boot copy stays at its reset value, not reloaded
            if (!swResetCause)
               d.sfr.bootApp = opt[`COD_IDX_BOOT][`COD_BIT_BOOTSEL];
            d.sfr.pinIsReset = opt[`COD_IDX_BOOT][`COD_BIT_RSTPIN];
            // brown-out copies reload on power-on only
            if (porCause)
            begin
               d.sfr.bodOn      = opt[`COD_IDX_BOD][`COD_BIT_BODON];
               d.sfr.bodLevel   = opt[`COD_IDX_BOD][`COD_BODLV_MSB:`COD_BODLV_LSB];
               d.sfr.bodInhibit = opt[`COD_IDX_BOD][`COD_BIT_BODINH];
               d.sfr.bodReset   = opt[`COD_IDX_BOD][`COD_BIT_BODRST];
            end
            d.phase = cod_pkg::ST_RUN;
         end
         cod_pkg::ST_RUN:
         begin
            if (sfrWe)
               d.sfr = sfrWdata;
         end
         default:
            d.phase = cod_pkg::ST_LOAD;
      endcase

      // external tool path, guarded by the lock
      if (toolReq.valid)
      begin
         d.toolAck = 1'b1;
         if (toolReq.eraseAll)
         begin
            storeErase   = 1'b1;
            d.flashErase = 1'b1;
         end
         else if (toolReq.optSel)
         begin
            if (!toolReq.write)
               d.toolRdata = opt[toolReq.idx];
            else if (!locked)
            begin
               storeWe  = 1'b1;
               storeIdx = toolReq.idx;
               storeWd  = toolReq.wdata;
            end
         end
         else if (!toolReq.write)
            d.toolRdata = locked ? `COD_BLANK : flashRdata;
         else
            d.flashWr = ~locked;
      end

      // in-application path ignores the lock; brown-out may block it
      if (iapReq.valid)
      begin
         d.iapAck = 1'b1;
         if (q.iapInhibit && (iapReq.write || iapReq.eraseAll))
            d.iapBlocked = 1'b1;
         else if (iapFlashOp)
            d.iapFlashWr = 1'b1;
         else if (iapReq.optSel && iapReq.write && !storeWe && !storeErase)
         begin
            storeWe  = 1'b1;
            storeIdx = iapReq.idx;
            storeWd  = iapReq.wdata;
         end
         else if (iapReq.write)
            d.iapBlocked = 1'b1;
      end

      d.loaderK = `COD_LDR_4K;
      d.appK    = `COD_APP_14K;
      case (opt[`COD_IDX_PART][`COD_LDSZ_MSB:`COD_LDSZ_LSB])
         3'h7:
         begin
            d.loaderK = `COD_LDR_0K;
            d.appK    = `COD_APP_18K;
         end
         3'h6:
         begin
            d.loaderK = `COD_LDR_1K;
            d.appK    = `COD_APP_17K;
         end
         3'h5:
         begin
            d.loaderK = `COD_LDR_2K;
            d.appK    = `COD_APP_16K;
         end
         3'h4:
         begin
            d.loaderK = `COD_LDR_3K;
            d.appK    = `COD_APP_15K;
         end
         default:
         begin
            d.loaderK = `COD_LDR_4K;
            d.appK    = `COD_APP_14K;
         end
      endcase

      case (q.sfr.bodLevel)
         2'h3:    d.bodDeciV = `COD_BOD_22;
         2'h2:    d.bodDeciV = `COD_BOD_27;
         2'h1:    d.bodDeciV = `COD_BOD_37;
         default: d.bodDeciV = `COD_BOD_44;
      endcase

      d.iapInhibit = q.sfr.bodInhibit & q.sfr.bodOn & bodBelowS;
      d.bodRstReq  = q.sfr.bodReset & q.sfr.bodOn & bodBelowS;

      d.dbgActive = ~opt[`COD_IDX_BOOT][`COD_BIT_DBGEN_N] & ~locked;

      // hard fault: set beats clear in the same cycle
      if (hardFaultClr)
         d.hardFaultFlag = 1'b0;
      if (hardFaultEv)
      begin
         d.hardFaultFlag = 1'b1;
         d.hardFaultRst  = ~q.dbgActive;
      end

      // debugger may only touch memory at a break or step halt
      if (dbgReq)
      begin
         if (q.dbgActive && cpuHalted)
            d.dbgAck = 1'b1;
         else
            d.dbgRefused = 1'b1;
      end

      d.pwmTri = {cod_pkg::PWM_CH{q.dbgActive & cpuHalted &
                 opt[`COD_IDX_BOOT][`COD_BIT_PWMTRI]}} & pwmPinOe;

      // the debugger watches its state on this clock
      d.oscOn = q.dbgActive | ~(swOscOff | powerDown);

      d.extRstReq = q.sfr.pinIsReset & ~resetPinS;
      d.gpioIn    = q.sfr.pinIsReset | resetPinS;
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         q            <= '0;
         q.phase      <= cod_pkg::ST_LOAD;
         q.sfr        <= '1;
         q.loaderK    <= `COD_LDR_0K;
         q.appK       <= `COD_APP_18K;
         q.bodDeciV   <= `COD_BOD_22;
         q.oscOn      <= 1'b1;
         q.gpioIn     <= 1'b1;
         q.toolRdata  <= `COD_BLANK;
      end
      else
         q <= d;
   end

   assign bootFromApp   = q.sfr.bootApp;
   assign loaderSizeK   = q.loaderK;
   assign appSizeK      = q.appK;
   assign bodEnable     = q.sfr.bodOn;
   assign bodDeciVolt   = q.bodDeciV;
   assign bodResetReq   = q.bodRstReq;
   assign iapInhibit    = q.iapInhibit;
   assign dbgActive     = q.dbgActive;
   assign pwmTristate   = q.pwmTri;
   assign hardFaultFlag = q.hardFaultFlag;
   assign hardFaultRst  = q.hardFaultRst;
   assign extResetReq   = q.extRstReq;
   assign gpioIn        = q.gpioIn;
   assign fastOscOn     = q.oscOn;
   assign toolRdata     = q.toolRdata;
   assign toolAck       = q.toolAck;
   assign flashWrite    = q.flashWr;
   assign flashErase    = q.flashErase;
   assign iapFlashWrite = q.iapFlashWr;
   assign iapAck        = q.iapAck;
   assign iapBlocked    = q.iapBlocked;
   assign dbgAck        = q.dbgAck;
   assign dbgRefused    = q.dbgRefused;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence loadStep;
      q.phase == cod_pkg::ST_LOAD && !swResetCause;
   endsequence
   sequence eraseStep;
      toolReq.valid && toolReq.eraseAll;
   endsequence
   sequence lockedFlashRead;
      toolReq.valid && !toolReq.eraseAll && !toolReq.optSel && !toolReq.write && locked;
   endsequence

   boot_load_a: assert property (loadStep |=> q.sfr.bootApp == $past(opt[0][7]))
      else $error("boot select not loaded after reset");
   pwm_float_a: assert property (q.dbgActive && cpuHalted && opt[0][5] && pwmPinOe[0] |=> q.pwmTri[0])
      else $error("pwm pin not floated at debug halt");
   fault_hold_a: assert property (hardFaultEv && q.dbgActive |=> !q.hardFaultRst && q.hardFaultFlag)
      else $error("hard fault reset in debug mode");
   lock_blank_a: assert property (lockedFlashRead |=> q.toolAck && q.toolRdata == 8'hFF)
      else $error("locked flash read not blank");
   opt_guard_a: assert property (toolReq.valid && toolReq.write && !toolReq.eraseAll && locked
                                 && !iapReq.valid |=> $stable(opt))
      else $error("locked option byte changed");
   erase_all_a: assert property (eraseStep |=> opt == {3{8'hFF}} ##1 !locked)
      else $error("whole erase left option bits");
   loader_dec_a: assert property (q.phase == cod_pkg::ST_RUN && !opt[1][2] |=> q.loaderK == 3'h4
                                  && q.appK == 5'h0E)
      else $error("loader size decode wrong");
   bod_inhibit_a: assert property (q.sfr.bodInhibit && q.sfr.bodOn && bodBelowS |=> q.iapInhibit)
      else $error("iap not inhibited below threshold");
   osc_keep_a: assert property (q.dbgActive && powerDown |=> q.oscOn)
      else $error("fast oscillator stopped in debug");
   dbg_halt_a: assert property (dbgReq && !cpuHalted |=> q.dbgRefused && !q.dbgAck)
      else $error("debugger access while running");
   dbg_lock_a: assert property (q.dbgActive |-> !$past(locked))
      else $error("debugger active on locked chip");

endmodule : cod_config_option_decoder

//--- sim/cod_tool_host.sv
// Purpose: programmer and debugger host model facing the option decoder
// Assumes: requests are one-cycle pulses taken on the rising edge
// Notes: released array data shows the inverse, so stale reads stand out
`timescale 1ns/1ps
module cod_tool_host (
   input  wire logic        clock,      // system clock
   output cod_pkg::cod_req_t toolReq,   // programmer request
   output logic [7:0]       flashRdata, // flash array data
   output logic             dbgReq      // debugger access pulse
);
   initial
   begin
      toolReq = '0;
      flashRdata = 8'h00;
      dbgReq = 1'b0;
   end
   // callers keep reserved option bits at one
   task automatic issue(input logic [2:0] wEo, input logic [1:0] i, input logic [7:0] d,
                        input logic [7:0] fd);
      @(posedge clock);
      toolReq <= '{1'b1, wEo[2], wEo[1], wEo[0], i, d};
      flashRdata <= fd;
      @(posedge clock);
      toolReq <= '0;
      flashRdata <= ~fd;
   endtask : issue
   // used while halted and while running, always out of power-down
   task automatic access;
      @(posedge clock);
      dbgReq <= 1'b1;
      @(posedge clock);
      dbgReq <= 1'b0;
   endtask : access
endmodule : cod_tool_host

//--- sim/cod_config_option_decoder_tb.sv
// Purpose: self-checking bench for the option decoder
// Assumes: option store erased before first real use
// Notes: ack results noted in queues and compared when the acks appear
`timescale 1ns/1ps
module cod_config_option_decoder_tb;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic porCause = 1'b1;
   logic cpuHalted = 1'b0;
   logic hardFaultEv = 1'b0;
   logic swOscOff = 1'b0;
   logic powerDown = 1'b0;
   logic bodBelowIn = 1'b0;
   logic swReset = 1'b0;
   logic resetPin = 1'b1;
   logic [5:0] pwmPinOe = 6'h00;
   cod_pkg::cod_req_t iapReq = '0;
   cod_pkg::cod_req_t toolReq;
   logic [7:0] flashRdata, toolRdata, fd, note8;
   logic [5:0] bodDeciVolt, pwmTristate;
   logic [4:0] appSizeK;
   logic [2:0] loaderSizeK, ld;
   logic dbgReq, bootFromApp, bodEnable, bodResetReq, iapInhibit, dbgActive, hardFaultFlag;
   logic fastOscOn, toolAck, flashWrite, flashErase, iapFlashWrite, iapAck, iapBlocked;
   logic dbgAck, dbgRefused, dn;
   logic hardFaultRst, extResetReq, gpioIn;
   logic [10:0] note;
   logic [10:0] toolQ[$];
   logic dbgQ[$];
   logic [7:0] lvl [4] = '{8'h2C, 8'h25, 8'h1B, 8'h16};
   int fails = 0;
   int compares = 0;

   always #2.5 clock = ~clock;

   cod_tool_host u_cod_tool_host (.clock, .toolReq, .flashRdata, .dbgReq);
   cod_config_option_decoder u_cod_config_option_decoder (
      .clock, .rst_b, .swResetCause(swReset), .porCause, .toolReq, .flashRdata, .iapReq,
      .sfrWe(1'b0), .sfrWdata('0), .cpuHalted, .dbgReq, .hardFaultEv, .hardFaultClr(1'b0),
      .swOscOff, .powerDown, .pwmPinOe, .resetPinIn(resetPin), .bodBelowIn, .bootFromApp,
      .loaderSizeK, .appSizeK, .bodEnable, .bodDeciVolt, .bodResetReq, .iapInhibit, .dbgActive,
      .pwmTristate, .hardFaultFlag, .hardFaultRst, .extResetReq, .gpioIn, .fastOscOn,
      .toolRdata, .toolAck, .flashWrite, .flashErase, .iapFlashWrite, .iapAck, .iapBlocked,
      .dbgAck, .dbgRefused);

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      compares++;
      if (s !== e)
      begin
         fails++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask : chk

   task automatic finish_test;
      if (toolQ.size() != 0 || dbgQ.size() != 0)
         fails++;
      if (fails == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test

   task automatic settle;
      repeat (3) @(posedge clock);
      #1;
   endtask : settle

   task automatic do_reset;
      @(posedge clock);
      rst_b <= 1'b0;
      repeat (5) @(posedge clock);
      rst_b <= 1'b1;
      repeat (6) @(posedge clock);
      #1;
   endtask : do_reset

   // note: {check data, erase strobe, write strobe, data}; flash read data 00 means the array byte
   task automatic tool(input logic [2:0] wEo, input logic [1:0] i, input logic [7:0] d,
                       input logic [10:0] n);
      fd = 8'($urandom);
      toolQ.push_back((n[10] && !wEo[0] && n[7:0] == 8'h00) ? {n[10:8], fd} : n);
      u_cod_tool_host.issue(wEo, i, d, fd);
   endtask : tool

   task automatic in_app_programming(input logic blk);
      @(posedge clock);
      iapReq <= '{1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 8'h5A};
      @(posedge clock);
      iapReq <= '0;
      #1;
      chk("iapBlocked", 8'(blk), 8'(iapBlocked));
      chk("iapFlashWrite", 8'(!blk), 8'(iapFlashWrite));
      chk("iapAck", 8'h01, 8'(iapAck));
   endtask : in_app_programming

   always @(posedge clock)
   begin
      if (toolAck === 1'b1)
      begin
         note = toolQ.pop_front();
         if (note[10])
            chk("toolRdata", note[7:0], toolRdata);
         chk("toolStrobes", 8'(note[9:8]), 8'({flashErase, flashWrite}));
      end
      if ((dbgAck | dbgRefused) === 1'b1)
      begin
         dn = dbgQ.pop_front();
         chk("dbgAck", 8'(dn), 8'(dbgAck));
         chk("dbgRefused", 8'(!dn), 8'(dbgRefused));
      end
   end

   initial
   begin
      #50000;
      fails++;
      finish_test;
   end

   initial
   begin
      void'($urandom(32'h51B1));
      // erase while held in reset, so the first load sees defined bytes
      u_cod_tool_host.issue(3'b010, 2'h0, 8'h00, 8'h00);
      do_reset;
      tool(3'b010, 2'h0, 8'h00, 11'h200);
      do_reset;
      chk("bootFromApp", 8'h01, 8'(bootFromApp));
      chk("dbgActive", 8'h00, 8'(dbgActive));
      for (int k = 0; k < 8; k++)
      begin
         tool(3'b101, 2'h1, 8'hF8 | 8'(k), 11'h000);
         settle;
         ld = (k == 7) ? 3'h0 : (k < 4) ? 3'h4 : 3'(7 - k);
         chk("loaderSizeK", 8'(ld), 8'(loaderSizeK));
         chk("appSizeK", 8'h12 - 8'(ld), 8'(appSizeK));
      end
      @(posedge clock);
      bodBelowIn <= 1'b1;
      for (int v = 0; v < 4; v++)
      begin
         tool(3'b101, 2'h2, {v[0], 1'b1, 2'(v), 4'hF}, 11'h000);
         do_reset;
         chk("bodDeciVolt", lvl[v], 8'(bodDeciVolt));
         chk("bodEnable", 8'(v[0]), 8'(bodEnable));
         chk("bodResetReq", 8'(v[0]), 8'(bodResetReq));
         chk("iapInhibit", 8'(v[0]), 8'(iapInhibit));
      end
      in_app_programming(1'b1);
      @(posedge clock);
      bodBelowIn <= 1'b0;
      tool(3'b101, 2'h0, 8'h6B, 11'h000);
      do_reset;
      chk("bootFromApp", 8'h00, 8'(bootFromApp));
      chk("dbgActive", 8'h01, 8'(dbgActive));
      swReset <= 1'b1;
      do_reset;
      chk("bootFromApp", 8'h01, 8'(bootFromApp));
      swReset <= 1'b0;
      resetPin <= 1'b0;
      settle;
      chk("gpioIn", 8'h00, 8'(gpioIn));
      chk("extResetReq", 8'h00, 8'(extResetReq));
      resetPin <= 1'b1;
      @(posedge clock);
      cpuHalted <= 1'b1;
      pwmPinOe <= 6'($urandom);
      hardFaultEv <= 1'b1;
      @(posedge clock);
      hardFaultEv <= 1'b0;
      #1;
      chk("hardFaultRst", 8'h00, 8'(hardFaultRst));
      settle;
      chk("pwmTristate", 8'(pwmPinOe), 8'(pwmTristate));
      chk("hardFaultFlag", 8'h01, 8'(hardFaultFlag));
      dbgQ.push_back(1'b1);
      u_cod_tool_host.access;
      cpuHalted <= 1'b0;
      dbgQ.push_back(1'b0);
      u_cod_tool_host.access;
      swOscOff <= 1'b1;
      powerDown <= 1'b1;
      settle;
      chk("fastOscOn", 8'h01, 8'(fastOscOn));
      tool(3'b000, 2'h0, 8'h00, 11'h400);
      tool(3'b100, 2'h0, 8'h3C, 11'h100);
      tool(3'b101, 2'h0, 8'hED, 11'h000);
      settle;
      chk("dbgActive", 8'h00, 8'(dbgActive));
      chk("fastOscOn", 8'h00, 8'(fastOscOn));
      @(posedge clock);
      hardFaultEv <= 1'b1;
      @(posedge clock);
      hardFaultEv <= 1'b0;
      #1;
      chk("hardFaultRst", 8'h01, 8'(hardFaultRst));
      tool(3'b000, 2'h0, 8'h00, 11'h4FF);
      tool(3'b100, 2'h0, 8'h3C, 11'h000);
      tool(3'b101, 2'h1, 8'hF8, 11'h000);
      tool(3'b001, 2'h1, 8'h00, 11'h4FF);
      in_app_programming(1'b0);
      tool(3'b010, 2'h0, 8'h00, 11'h200);
      do_reset;
      chk("bootFromApp", 8'h01, 8'(bootFromApp));
      resetPin <= 1'b0;
      settle;
      chk("gpioIn", 8'h01, 8'(gpioIn));
      chk("extResetReq", 8'h01, 8'(extResetReq));
      tool(3'b001, 2'h0, 8'h00, 11'h4FF);
      tool(3'b000, 2'h0, 8'h00, 11'h400);
      settle;
      finish_test;
   end
endmodule : cod_config_option_decoder_tb
